// ---- pkg/hfh_defines.svh ----
`ifndef HFH_DEFINES_SVH
`define HFH_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define HFH_REG_STAT1 8'h20
`define HFH_REG_MASK1 8'h21
`define HFH_REG_STAT2 8'h22
`define HFH_REG_MASK2 8'h23
`define HFH_REG_EVT_INFO 8'h2D
`define HFH_REG_INFO1 8'h2E
`define HFH_REG_INFO2 8'h2F
`define HFH_REG_RXCNT1 8'h9C
`define HFH_REG_TF1 8'h9D
`define HFH_REG_RF1 8'h9E
`define HFH_REG_TXSPC1 8'h9F
`define HFH_REG_RXCNT2 8'hAC
`define HFH_REG_TF2 8'hAD
`define HFH_REG_RF2 8'hAE
`define HFH_REG_TXSPC2 8'hAF
`define HFH_REG_TEND1 8'hB0
`define HFH_REG_TEND2 8'hB1

// ----------------------------------------------------------------
// Field positions, codes and reset values
// ----------------------------------------------------------------
`define HFH_RESET_VAL 8'h00
`define HFH_INFO_RX_FIFO_EMPTY_FLAG 3
`define HFH_INFO_TX_FIFO_FULL_FLAG 4
`define HFH_INFO_TX_FIFO_EMPTY_FLAG 5
`define HFH_PS_PROGRESS 3'h0
`define HFH_PS_OK 3'h1
`define HFH_PS_CRC 3'h2
`define HFH_PS_ABORT 3'h3
`define HFH_PS_OVERRUN 3'h4
`define HFH_FIFO_DEPTH 128
`define HFH_COUNT_MAX 7'h7F
`define HFH_ABORT_RUN 7

`endif

// ---- pkg/hfh_pkg.sv ----
package hfh_pkg;

	// Entry of a receive FIFO: one byte with its packet markers.
	typedef struct packed {
		logic [7:0] data;
		logic sof;
		logic eom;
		logic [2:0] st;
	} hfh_rx_ent_t;

	// Entry of a transmit FIFO: one byte and its end-of-message tag.
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} hfh_tx_ent_t;

	// Byte- and bit-level receive side of one controller's framing engine.
	typedef struct packed {
		logic valid;
		logic first;
		logic pkt_end;
		logic crc_ok;
		logic bit_en;
		logic bit_val;
		logic [7:0] data;
	} hfh_rx_link_t;

endpackage

// ---- rtl/hfh_fifo.sv ----
`timescale 1ns/1ps
module hfh_fifo
	import hfh_pkg::*;
#(
	parameter int W = 8,
	parameter int DEPTH = 128
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1)
		$error("hfh_fifo needs a power-of-two depth of at least 2");

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;
	logic do_wr;
	logic do_rd;

	// Full and empty come straight from the pointers, so they never lie.
	assign count = wptr_q - rptr_q;
	assign wr_ready = (count != DEPTH[AW:0]);
	assign rd_valid = (count != '0);
	assign do_wr = wr_valid & wr_ready;
	assign do_rd = rd_ready & rd_valid;
	assign rd_data = mem_q[rptr_q[AW-1:0]];

	// Storage has no reset; only the pointers define what is valid.
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem_q[wptr_q[AW-1:0]] <= wr_data;
	end

	// Pointers advance on accepted writes and reads.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
		end
		else
		begin
			if (do_wr)
				wptr_q <= wptr_q + 1'b1;
			if (do_rd)
				rptr_q <= rptr_q + 1'b1;
		end
	end
endmodule

// ---- rtl/hfh_ones_det.sv ----
`timescale 1ns/1ps
module hfh_ones_det
#(
	parameter int RUN = 7
)(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bit_en,
	input wire logic bit_val,
	output logic abort
);
	localparam int CW = $clog2(RUN + 1);

	if (RUN < 2)
		$error("hfh_ones_det needs a run length of at least 2");

	logic [CW-1:0] run_q;

	// Saturating count of consecutive ones; a zero restarts it.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			run_q <= '0;
		else if (bit_en)
			run_q <= !bit_val ? '0 : (run_q == RUN[CW-1:0]) ? run_q : run_q + 1'b1;
	end

	// One pulse per run, on the bit that makes it long enough.
	assign abort = bit_en & bit_val & (run_q == CW'(RUN - 1));
endmodule

// ---- rtl/hfh_top.sv ----
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`include "hfh_defines.svh"
module hfh_top
	import hfh_pkg::*;
#(
	parameter int DEPTH = `HFH_FIFO_DEPTH,
	parameter int TX_LOW_MARK = 16,
	parameter int RX_HIGH_MARK = 96
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire hfh_rx_link_t [1:0] rx_link,
	output logic [1:0] tx_valid,
	input wire logic [1:0] tx_ready,
	output hfh_tx_ent_t [1:0] tx_data,
	output logic [1:0] tx_abort,
	output logic [1:0] irq
);
	localparam int CW = $clog2(DEPTH) + 1;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (DEPTH < 2 || DEPTH > 128 || TX_LOW_MARK >= DEPTH || RX_HIGH_MARK >= DEPTH)
		$error("hfh_top depth must be 2..128 and both marks below it");

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic setup;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic [7:0] rd_val;
	logic [31:0] prdata_q;
	logic [7:0] st_val [2];
	logic [7:0] mask_q [2];
	logic [7:0] info_val [2];
	logic [7:0] rx_cnt_val [2];
	logic [7:0] tx_spc_val [2];
	logic [7:0] rf_val [2];
	logic [1:0] udr_q;
	logic [1:0] obt;

	// Every access completes with no wait state; data was taken at setup.
	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = psel & penable & ~mapped;

	// Read multiplexer and address decode over both controllers.
	always_comb
	begin
		rd_val = `HFH_RESET_VAL;
		mapped = 1'b1;
		case (idx)
			`HFH_REG_STAT1: rd_val = st_val[0];
			`HFH_REG_MASK1: rd_val = mask_q[0];
			`HFH_REG_STAT2: rd_val = st_val[1];
			`HFH_REG_MASK2: rd_val = mask_q[1];
			`HFH_REG_EVT_INFO: rd_val = {4'h0, udr_q[1], obt[1], udr_q[0], obt[0]};
			`HFH_REG_INFO1: rd_val = info_val[0];
			`HFH_REG_INFO2: rd_val = info_val[1];
			`HFH_REG_RXCNT1: rd_val = rx_cnt_val[0];
			`HFH_REG_RF1: rd_val = rf_val[0];
			`HFH_REG_TXSPC1: rd_val = tx_spc_val[0];
			`HFH_REG_RXCNT2: rd_val = rx_cnt_val[1];
			`HFH_REG_RF2: rd_val = rf_val[1];
			`HFH_REG_TXSPC2: rd_val = tx_spc_val[1];
			`HFH_REG_TF1, `HFH_REG_TF2, `HFH_REG_TEND1, `HFH_REG_TEND2: rd_val = `HFH_RESET_VAL;
			default: mapped = 1'b0;
		endcase
	end

	// Read data is captured in the setup phase and held through access.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (setup)
			prdata_q <= {24'h00_0000, rd_val};
	end

	// ----------------------------------------------------------------
	// Per-controller logic
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : g_ctrl
		localparam logic [7:0] A_ST = (g == 0) ? `HFH_REG_STAT1 : `HFH_REG_STAT2;
		localparam logic [7:0] A_MASK = (g == 0) ? `HFH_REG_MASK1 : `HFH_REG_MASK2;
		localparam logic [7:0] A_TF = (g == 0) ? `HFH_REG_TF1 : `HFH_REG_TF2;
		localparam logic [7:0] A_TEND = (g == 0) ? `HFH_REG_TEND1 : `HFH_REG_TEND2;
		localparam logic [7:0] A_RF = (g == 0) ? `HFH_REG_RF1 : `HFH_REG_RF2;

		logic st_rd;
		logic evi_rd;
		logic tx_push;
		logic tx_nfull;
		logic tx_nempty;
		logic tx_pop;
		hfh_tx_ent_t tx_wdata;
		hfh_tx_ent_t tx_head;
		logic [CW-1:0] tx_cnt;
		logic in_msg_q;
		logic underrun;
		logic tx_abort_q;
		logic abort_det;
		hfh_rx_ent_t stage_q;
		hfh_rx_ent_t stage_d;
		logic stage_v_q;
		logic stage_v_d;
		logic drop_q;
		logic drop_d;
		logic rx_push;
		logic rps_set;
		logic rpe_set;
		logic rx_nfull;
		logic rx_nempty;
		logic rx_pop;
		hfh_rx_ent_t rx_head;
		logic [CW-1:0] rx_cnt;
		logic [7:0] wr_len_q;
		logic [7:0] rd_cur_q;
		logic len_nempty;
		logic [7:0] len_head;
		logic [7:0] avail;
		logic [2:0] ps_q;
		logic [3:0] cond;
		logic [3:0] cond_q;
		logic [3:0] edge_q;
		logic [6:4] evt_q;

		assign st_rd = rd_acc & (idx == A_ST);
		assign evi_rd = rd_acc & (idx == `HFH_REG_EVT_INFO);

		// Mask register, written whole; bit 7 is reserved and reads zero.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				mask_q[g] <= `HFH_RESET_VAL;
			else if (wr_acc && idx == A_MASK)
				mask_q[g] <= {1'b0, pwdata[6:0]};
		end

		// ------------------------------------------------------------
		// Transmit path
		// ------------------------------------------------------------
		// A write to the end-data register tags its byte as the message's last.
		assign tx_push = wr_acc & ((idx == A_TF) | (idx == A_TEND));
		assign tx_wdata = '{data: pwdata[7:0], last: (idx == A_TEND)};

		hfh_fifo #(.W($bits(hfh_tx_ent_t)), .DEPTH(DEPTH)) u_tx_fifo (
			.clk(pclk),
			.rst_n(presetn),
			.wr_valid(tx_push),
			.wr_ready(tx_nfull),
			.wr_data(tx_wdata),
			.rd_valid(tx_nempty),
			.rd_ready(tx_ready[g]),
			.rd_data(tx_head),
			.count(tx_cnt)
		);

		assign tx_valid[g] = tx_nempty;
		assign tx_data[g] = tx_head;
		assign tx_pop = tx_nempty & tx_ready[g];
		assign tx_abort[g] = tx_abort_q;
		// The engine asks for a byte mid-message and none is there.
		assign underrun = in_msg_q & tx_ready[g] & ~tx_nempty;
		assign tx_spc_val[g] = 8'(DEPTH - int'(tx_cnt));

		// Message tracking and the automatic abort on underrun.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				in_msg_q <= 1'b0;
				tx_abort_q <= 1'b0;
			end
			else
			begin
				tx_abort_q <= underrun;
				if (underrun)
					in_msg_q <= 1'b0;
				else if (tx_pop)
					in_msg_q <= ~tx_head.last;
			end
		end

		// Underrun flag; a new underrun beats the read that clears the old one.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				udr_q[g] <= 1'b0;
			else
				udr_q[g] <= underrun | (udr_q[g] & ~(evi_rd & prdata_q[2*g+1]));
		end

		// ------------------------------------------------------------
		// Receive path
		// ------------------------------------------------------------
		hfh_ones_det #(.RUN(`HFH_ABORT_RUN)) u_ones (
			.clk(pclk),
			.rst_n(presetn),
			.bit_en(rx_link[g].bit_en),
			.bit_val(rx_link[g].bit_val),
			.abort(abort_det)
		);

		// One byte is staged so that its end status can be attached before it
		// enters the FIFO; an abort or overrun then needs no extra entry.
		always_comb
		begin
			stage_d = stage_q;
			stage_v_d = stage_v_q;
			drop_d = drop_q;
			rx_push = 1'b0;
			rps_set = 1'b0;
			rpe_set = 1'b0;
			if (stage_v_q && stage_q.eom && rx_nfull)
			begin
				rx_push = 1'b1;
				stage_v_d = 1'b0;
			end
			if (rx_link[g].valid && (!drop_q || rx_link[g].first))
			begin
				drop_d = 1'b0;
				rps_set = rx_link[g].first;
				if (stage_v_d && !stage_q.eom && !rx_nfull)
				begin
					stage_d.eom = 1'b1;
					stage_d.st = `HFH_PS_OVERRUN;
					drop_d = 1'b1;
					rpe_set = 1'b1;
				end
				else if (stage_v_d && stage_q.eom)
					drop_d = 1'b1;
				else
				begin
					rx_push = stage_v_d;
					stage_v_d = 1'b1;
					stage_d = '{data: rx_link[g].data, sof: rx_link[g].first, eom: 1'b0, st: `HFH_PS_PROGRESS};
				end
			end
			if ((rx_link[g].pkt_end || abort_det) && stage_v_d && !stage_d.eom)
			begin
				stage_d.eom = 1'b1;
				stage_d.st = abort_det ? `HFH_PS_ABORT : rx_link[g].crc_ok ? `HFH_PS_OK : `HFH_PS_CRC;
				rpe_set = 1'b1;
			end
			if (rx_link[g].pkt_end || abort_det)
				drop_d = 1'b0;
		end

		// Staging register state.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				stage_q <= '0;
				stage_v_q <= 1'b0;
				drop_q <= 1'b0;
			end
			else
			begin
				stage_q <= stage_d;
				stage_v_q <= stage_v_d;
				drop_q <= drop_d;
			end
		end

		hfh_fifo #(.W($bits(hfh_rx_ent_t)), .DEPTH(DEPTH)) u_rx_fifo (
			.clk(pclk),
			.rst_n(presetn),
			.wr_valid(rx_push),
			.wr_ready(rx_nfull),
			.wr_data(stage_q),
			.rd_valid(rx_nempty),
			.rd_ready(rx_pop),
			.rd_data(rx_head),
			.count(rx_cnt)
		);

		// Lengths of whole messages in the FIFO, one entry per ending byte.
		hfh_fifo #(.W(8), .DEPTH(DEPTH)) u_len_fifo (
			.clk(pclk),
			.rst_n(presetn),
			.wr_valid(rx_push & stage_q.eom),
			.wr_ready(),
			.wr_data(wr_len_q + 8'h01),
			.rd_valid(len_nempty),
			.rd_ready(rx_pop & rx_head.eom),
			.rd_data(len_head),
			.count()
		);

		assign rx_pop = rd_acc & (idx == A_RF) & rx_nempty;
		assign rf_val[g] = rx_nempty ? rx_head.data : `HFH_RESET_VAL;
		assign obt[g] = rx_nempty & rx_head.sof;

		// Byte counts on both sides of the FIFO, per message.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				wr_len_q <= 8'h00;
				rd_cur_q <= 8'h00;
			end
			else
			begin
				if (rx_push)
					wr_len_q <= stage_q.eom ? 8'h00 : wr_len_q + 8'h01;
				if (rx_pop)
					rd_cur_q <= rx_head.eom ? 8'h00 : rd_cur_q + 8'h01;
			end
		end

		// Readable bytes stop at the first message end still in the FIFO.
		assign avail = len_nempty ? (len_head - rd_cur_q) : 8'(rx_cnt);
		assign rx_cnt_val[g] = {~len_nempty | (avail > 8'h7F),
			(avail > 8'h7F) ? `HFH_COUNT_MAX : avail[6:0]};

		// Packet status follows each read of the receive FIFO.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				ps_q <= `HFH_PS_PROGRESS;
			else if (rx_pop)
				ps_q <= rx_head.eom ? rx_head.st : `HFH_PS_PROGRESS;
		end

		assign info_val[g] = {2'b00, ~tx_nempty, ~tx_nfull, ~rx_nempty, ps_q};

		// ------------------------------------------------------------
		// Status, events and interrupt
		// ------------------------------------------------------------
		assign cond[0] = tx_nfull;
		assign cond[1] = (int'(tx_cnt) < TX_LOW_MARK);
		assign cond[2] = rx_nempty;
		assign cond[3] = (int'(rx_cnt) > RX_HIGH_MARK);
		assign st_val[g] = {1'b0, evt_q, cond};

		// Condition history for edge detection.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				cond_q <= 4'h0;
			else
				cond_q <= cond;
		end

		// Pending rises of enabled conditions; a status read clears them, but a
		// rise in the same cycle wins.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				edge_q <= 4'h0;
			else
				edge_q <= (cond & ~cond_q & mask_q[g][3:0]) | (edge_q & {4{~st_rd}});
		end

		// Latched events clear only for bits the host actually saw set.
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				evt_q <= 3'h0;
			else
				evt_q <= {tx_pop & tx_head.last, rpe_set, rps_set} | (evt_q & ~({3{st_rd}} & prdata_q[6:4]));
		end

		// Request stays high while any enabled event is pending.
		assign irq[g] = (|edge_q) | (|(evt_q & mask_q[g][6:4]));
	end
endmodule

// ---- verif/hfh_top_properties.sv ----
`timescale 1ns/1ps
module hfh_top_properties
	import hfh_pkg::*;
#(
	parameter int DEPTH = 128
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire hfh_rx_link_t [1:0] rx_link,
	input wire logic [1:0] tx_valid,
	input wire logic [1:0] tx_ready,
	input wire hfh_tx_ent_t [1:0] tx_data,
	input wire logic [1:0] tx_abort,
	input wire logic [1:0] irq
);
	// ----------------------------------------
	// Helper logic
	// ----------------------------------------
	logic [7:0] idx;
	logic acc;
	logic starve;
	logic [6:0] mask1_q;
	logic [6:0] mask2_q;
	// Decoded bus phase and a starved second transmit engine.
	assign idx = paddr[9:2];
	assign acc = psel && penable;
	assign starve = tx_ready[1] && !tx_valid[1];
	// Shadow masks, so irq is judged without looking inside the block.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mask1_q <= 7'h00;
			mask2_q <= 7'h00;
		end
		else if (acc && pwrite)
		begin
			if (idx == 8'h21) mask1_q <= pwdata[6:0];
			if (idx == 8'h23) mask2_q <= pwdata[6:0];
		end
	end
	function automatic logic mapped(input logic [7:0] i);
		return i inside {8'h20, 8'h21, 8'h22, 8'h23, 8'h2D, 8'h2E, 8'h2F, 8'h9C, 8'h9D, 8'h9E, 8'h9F,
			8'hAC, 8'hAD, 8'hAE, 8'hAF, 8'hB0, 8'hB1};
	endfunction
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A read is a setup phase at one index followed by its access phase.
	sequence s_rd(logic [7:0] ix);
		psel && !penable && !pwrite && idx == ix ##1 acc;
	endsequence
	a_space_bound: assert property (s_rd(8'h9F) |-> prdata[7:0] <= DEPTH)
		else $error("tx space above depth");
	a_status_code: assert property (s_rd(8'h2E) |-> prdata[2:0] <= 3'h4)
		else $error("undefined packet status");
	a_empty_flag: assert property (s_rd(8'h2E) |-> prdata[5] == !$past(tx_valid[0]))
		else $error("tx empty flag wrong");
	a_unmapped_err: assert property (pslverr == (acc && !mapped(idx)))
		else $error("slave error wrong");
	a_upper_zero: assert property (acc |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_ready_high: assert property (pready)
		else $error("wait state seen");
	a_abort_cause: assert property ($rose(tx_abort[1]) |-> $past(starve))
		else $error("abort without starvation");
	a_abort_pulse: assert property (tx_abort[1] |=> !tx_abort[1])
		else $error("abort longer than one cycle");
	a_irq_masked: assert property (mask1_q == 7'h00 |-> !irq[0])
		else $error("masked irq raised");
	a_irq2_masked: assert property (mask2_q == 7'h00 |-> !irq[1])
		else $error("masked irq raised");
	a_head_stands: assert property (tx_valid[0] && !tx_ready[0] |=> $stable(tx_data[0]))
		else $error("tx head moved");
endmodule

// ---- verif/hfh_link_model.sv ----
`timescale 1ns/1ps
module hfh_link_model
	import hfh_pkg::*;
(
	input wire logic pclk,
	input wire logic [1:0] hold,
	input wire logic [1:0] tx_valid,
	input wire hfh_tx_ent_t [1:0] tx_data,
	output hfh_rx_link_t [1:0] rx_link,
	output logic [1:0] tx_ready
);
	integer seed = 32'h30fa_eea0;
	hfh_tx_ent_t popq[$];
	initial
	begin
		rx_link = '0;
		tx_ready = 2'b00;
	end
	// The engine takes bytes at random moments, never while held.
	always @(posedge pclk)
	begin
		if (tx_valid[0] && tx_ready[0]) popq.push_back(tx_data[0]);
		tx_ready <= ~hold & 2'($random(seed));
	end
	// One byte per strobe; the idle data lines show the inverse value.
	task automatic send_byte(input int g, input logic [7:0] dv, input logic f);
		@(posedge pclk);
		rx_link[g].valid <= 1'b1;
		rx_link[g].first <= f;
		rx_link[g].data <= dv;
		@(posedge pclk);
		rx_link[g].valid <= 1'b0;
		rx_link[g].first <= 1'b0;
		rx_link[g].data <= ~dv;
	endtask
	// Kind 1 good closing flag, 2 bad CRC, 3 a zero then seven ones.
	task automatic send_end(input int g, input int kind);
		@(posedge pclk);
		if (kind == 3)
		begin
			rx_link[g].bit_en <= 1'b1;
			rx_link[g].bit_val <= 1'b0;
			repeat (7) @(posedge pclk) rx_link[g].bit_val <= 1'b1;
			@(posedge pclk);
			rx_link[g].bit_en <= 1'b0;
		end
		else
		begin
			rx_link[g].pkt_end <= 1'b1;
			rx_link[g].crc_ok <= kind == 1;
			@(posedge pclk);
			rx_link[g].pkt_end <= 1'b0;
		end
	endtask
endmodule

// ---- verif/hfh_top_tb.sv ----
`timescale 1ns/1ps
module hfh_top_tb
	import hfh_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	hfh_rx_link_t [1:0] rx_link;
	hfh_tx_ent_t [1:0] tx_data;
	logic [1:0] tx_valid, tx_ready, tx_abort, irq;
	logic [1:0] hold = 2'b11;
	integer seed = 32'h30fa_eea0;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	int i, k, n, code;
	logic [31:0] d;
	logic e;
	logic [7:0] pkt[$];
	always #12.5 pclk = ~pclk;
	hfh_top i_hfh_top(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_link(rx_link), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.tx_abort(tx_abort), .irq(irq));
	hfh_link_model i_hfh_link_model(.pclk(pclk), .hold(hold), .tx_valid(tx_valid), .tx_data(tx_data),
		.rx_link(rx_link), .tx_ready(tx_ready));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request is held until pready is seen high; data and error taken there.
	task automatic apb(input logic wr, input logic [7:0] ix, input logic [7:0] wd);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {ix, 2'b00};
		pwdata <= {24'h00_0000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		@(posedge pclk);
		while (pready !== 1'b1 && t < 100)
		begin
			t++;
			@(posedge pclk);
		end
		if (t >= 100)
			n_fail++;
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A hung wait is cut short well beyond the expected run length.
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h2E, 8'h00); chk(d, 32'h0000_0028);
		apb(0, 8'h2F, 8'h00); chk(d, 32'h0000_0028);
		apb(1, 8'h9F, 8'h55);
		apb(0, 8'h9F, 8'h00); chk(d, 32'h0000_0080);
		apb(1, 8'h21, 8'h24);
		apb(0, 8'h21, 8'h00); chk(d, 32'h0000_0024);
		apb(0, 8'h07, 8'h00); chk({e, d[30:0]}, 32'h8000_0000);
		// Fill the first transmit FIFO while its engine is held, then drain it.
		for (i = 0; i < 128; i++)
		begin
			pkt.push_back(8'($random(seed)));
			apb(1, (i == 127) ? 8'hB0 : 8'h9D, pkt[i]);
		end
		apb(1, 8'h9D, 8'hEE);
		apb(0, 8'h9F, 8'h00); chk(d, 32'h0000_0000);
		apb(0, 8'h2E, 8'h00); chk(d, 32'h0000_0018);
		apb(0, 8'h20, 8'h00); chk(d, 32'h0000_0000);
		hold[0] <= 1'b0;
		for (k = 0; k < 2000 && tx_valid[0] !== 1'b0; k++) @(posedge pclk);
		chk(i_hfh_link_model.popq.size(), 128);
		for (i = 0; i < 128; i++) chk(i_hfh_link_model.popq[i], {pkt[i], i == 127});
		apb(0, 8'h20, 8'h00); chk(d, 32'h0000_0043);
		// Second controller runs dry in mid-message.
		apb(1, 8'hAD, 8'h11);
		apb(1, 8'hAD, 8'h22);
		hold[1] <= 1'b0;
		for (k = 0; k < 300 && tx_abort[1] !== 1'b1; k++) @(posedge pclk);
		chk({31'h0, tx_abort[1]}, 32'h1);
		apb(0, 8'h2D, 8'h00); chk(d, 32'h0000_0008);
		apb(0, 8'h2D, 8'h00); chk(d, 32'h0000_0000);
		// Receive packets ending good, bad CRC, aborted, and one left open.
		for (k = 0; k < 4; k++)
		begin
			code = (k + 1) % 4;
			n = 2 + ($unsigned($random(seed)) % 4);
			pkt = {};
			for (i = 0; i < n; i++)
			begin
				pkt.push_back(8'($random(seed)));
				i_hfh_link_model.send_byte(0, pkt[i], i == 0);
			end
			if (code != 0) i_hfh_link_model.send_end(0, code);
			repeat (4) @(posedge pclk);
			chk({31'h0, irq[0]}, 32'h1);
			apb(0, 8'h2D, 8'h00); chk(d, 32'h0000_0001);
			apb(0, 8'h9C, 8'h00); chk(d, (code == 0) ? 32'(127 + n) : 32'(n));
			apb(0, 8'h20, 8'h00); chk(d & 32'h30, (code == 0) ? 32'h10 : 32'h30);
			apb(0, 8'h20, 8'h00); chk(d & 32'h30, 32'h0000_0000);
			chk({31'h0, irq[0]}, 32'h0);
			for (i = 0; i < ((code == 0) ? n - 1 : n); i++)
			begin
				apb(0, 8'h9E, 8'h00); chk(d, 32'(pkt[i]));
			end
			// The open packet's last byte stays staged, so the FIFO is empty in every case.
			apb(0, 8'h2E, 8'h00); chk(d, 32'(40 + code));
		end
		// A packet longer than the receive FIFO ends in overrun.
		for (i = 0; i < 131; i++) i_hfh_link_model.send_byte(0, 8'($random(seed)), i == 0);
		repeat (4) @(posedge pclk);
		k = 0;
		do
		begin
			apb(0, 8'h9E, 8'h00);
			apb(0, 8'h2E, 8'h00);
			k++;
		end
		while (d[3] !== 1'b1 && k < 200);
		chk(d & 32'h0F, 32'h0000_000C);
		give_verdict();
	end
endmodule
bind hfh_top hfh_top_properties #(.DEPTH(DEPTH)) i_hfh_top_properties(.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_link(rx_link), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_data(tx_data), .tx_abort(tx_abort), .irq(irq));
